/* File: include/aec_defines.svh */
// register offsets, field positions, reset values and interrupt vector for the event counter
// Function
// - read-only 8-bit upper up-counter, standalone or high byte
// - upper clock: pin, clock/2/4/8, lower overflow
// - read-only lower counter: pin or clock/2/4/8
// - counters zero on reset, software clearable
// - standby bit 3: 0 halts, resets 1
// - split bit 0: one 16-bit counter, lower select
// - lower edge field picks counted lower pin edges
// - counters advance only while gate is high
// - after reset: 16-bit, lower pin falling edges
// - 16-bit wrap sets upper overflow, keeps counting
// - overflow sets counter request, interrupt when enabled
// - split bit 1: independent, upper select field
// - upper edge field picks counted upper pin edges
// - 8-bit upper wrap sets upper overflow flag
// - 8-bit lower wrap sets lower overflow flag
// - pwm gate off: gate pin gates both
// - gate pin is interrupt source, vector 6
// - gate event sets request, interrupt when enabled
// - gate interrupt edge: rising, falling or both
// - pwm gate on: pwm output gates both
// - pwm edges raise same gate request flag
// - count enable 0 holds count, 1 advances
// - reset control 0 holds counter cleared
// - overflow flag cleared by write 0 after read
`ifndef AEC_DEFINES_SVH
`define AEC_DEFINES_SVH
`define AEC_OFS_UPPER_COUNT 4'h0
`define AEC_OFS_LOWER_COUNT 4'h1
`define AEC_OFS_CLOCK_STOP 4'h2
`define AEC_OFS_CTRL_STATUS 4'h3
`define AEC_OFS_CLOCK_SELECT 4'h4
`define AEC_OFS_EDGE_GATE 4'h5
`define AEC_OFS_PWM_CMP_HI 4'h6
`define AEC_OFS_PWM_CMP_LO 4'h7
`define AEC_OFS_PWM_DAT_HI 4'h8
`define AEC_OFS_PWM_DAT_LO 4'h9
`define AEC_OFS_IRQ_REQ_ONE 4'hA
`define AEC_OFS_IRQ_EN_ONE 4'hB
`define AEC_OFS_IRQ_REQ_TWO 4'hC
`define AEC_OFS_IRQ_EN_TWO 4'hD
`define AEC_RST_CLOCK_STOP 8'hFF
`define AEC_RST_ZERO 8'h00
`define AEC_BIT_STANDBY 3
`define AEC_BIT_OVH 7
`define AEC_BIT_OVL 6
`define AEC_BIT_SPLIT 4
`define AEC_BIT_UPPER_COUNT_ENABLE 3
`define AEC_BIT_CUEL 2
`define AEC_BIT_UPPER_RESET_CONTROL 1
`define AEC_BIT_CRCL 0
`define AEC_BIT_PWM_GATE 0
`define AEC_BIT_REQ 0
`define AEC_SEL_PIN 2'h0
`define AEC_VECTOR_NUM 6
`define AEC_VECTOR_ADDR 16'h000C
`endif

/* File: include/aec_pkg.sv */
// shared types for the asynchronous event counter
package aec_pkg;
  typedef logic [7:0] aec_byte_t;
  typedef logic [3:0] aec_addr_t;
  typedef logic [15:0] aec_word_t;
endpackage

/* File: design/aec_top.sv */
// asynchronous event counter: two 8-bit counters, pwm gate and register port
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "aec_defines.svh"
module aec_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire aec_pkg::aec_addr_t reg_addr,
  input wire aec_pkg::aec_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output aec_pkg::aec_byte_t reg_rdata,
  input wire logic upper_event_pin,
  input wire logic lower_event_pin,
  input wire logic gate_pin,
  output logic internal_gate_pwm_out,
  output logic counter_irq,
  output logic gate_irq
);
  import aec_pkg::*;

  // edge match: 00 falling, 01 rising, 1x both
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    logic hit;
    hit = 1'b0;
    if (sel[1]) begin
      hit = rise | fall;
    end else if (sel[0]) begin
      hit = rise;
    end else begin
      hit = fall;
    end
    return hit;
  endfunction

  // one-cycle tick every 2^n system clocks, taken from the free divider
  function automatic logic div_tick(input logic [5:0] div, input logic [2:0] n);
    logic [5:0] mask;
    mask = 6'h3F >> (3'h6 - n);
    return (div & mask) == mask;
  endfunction

  // counter source: pin event or system clock / 2, 4, 8
  function automatic logic src_tick(input logic [1:0] sel, input logic pin_evt,
                                    input logic [5:0] div);
    logic t;
    t = 1'b0;
    unique case (sel)
      2'h0: t = pin_evt;
      2'h1: t = div_tick(div, 3'h1);
      2'h2: t = div_tick(div, 3'h2);
      2'h3: t = div_tick(div, 3'h3);
    endcase
    return t;
  endfunction

  aec_byte_t upper_counter_reg;
  aec_byte_t lower_counter_reg;
  aec_byte_t clock_stop_reg;
  aec_byte_t ctrl_status_reg;
  aec_byte_t clock_select_reg;
  aec_byte_t edge_gate_reg;
  aec_word_t pwm_compare_reg;
  aec_word_t pwm_data_reg;
  aec_word_t pwm_count_reg;
  logic gate_request_flag_reg;
  logic gate_irq_enable_reg;
  logic counter_request_flag_reg;
  logic counter_irq_enable_reg;
  logic ovh_armed_reg;
  logic ovl_armed_reg;
  logic [5:0] div_reg;
  logic [1:0] upper_sync_reg;
  logic [1:0] lower_sync_reg;
  logic [1:0] gate_sync_reg;
  logic upper_prev_reg;
  logic lower_prev_reg;
  logic gate_prev_reg;
  logic pwm_prev_reg;

  logic running;
  logic split;
  logic pwm_gate_en;
  logic gate_level;
  logic upper_pin_evt;
  logic lower_pin_evt;
  logic lower_tick;
  logic lower_wrap;
  logic upper_src;
  logic upper_tick;
  logic upper_wrap;
  logic gate_event;
  logic pwm_src_tick;
  logic [2:0] pwm_div_n;
  logic wr_ctrl;
  logic rd_ctrl;

  assign running = clock_stop_reg[`AEC_BIT_STANDBY];
  assign split = ctrl_status_reg[`AEC_BIT_SPLIT];
  assign pwm_gate_en = edge_gate_reg[`AEC_BIT_PWM_GATE];
  assign wr_ctrl = reg_wr && (reg_addr == `AEC_OFS_CTRL_STATUS);
  assign rd_ctrl = reg_rd && (reg_addr == `AEC_OFS_CTRL_STATUS);

  // pins are asynchronous: two flops before any logic looks at them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      upper_sync_reg <= 2'h0;
      lower_sync_reg <= 2'h0;
      gate_sync_reg <= 2'h0;
    end else if (clk_en) begin
      upper_sync_reg <= {upper_sync_reg[0], upper_event_pin};
      lower_sync_reg <= {lower_sync_reg[0], lower_event_pin};
      gate_sync_reg <= {gate_sync_reg[0], gate_pin};
    end
  end

  // previous levels for edge detection: pins from the second stage, gate from gate_level, pwm from its output
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      upper_prev_reg <= 1'b0;
      lower_prev_reg <= 1'b0;
      gate_prev_reg <= 1'b0;
      pwm_prev_reg <= 1'b0;
    end else if (clk_en) begin
      upper_prev_reg <= upper_sync_reg[1];
      lower_prev_reg <= lower_sync_reg[1];
      gate_prev_reg <= gate_level;
      pwm_prev_reg <= internal_gate_pwm_out;
    end
  end

  // pin events through the edge select fields
  assign lower_pin_evt = edge_hit(edge_gate_reg[5:4], lower_sync_reg[1] & ~lower_prev_reg,
                                  ~lower_sync_reg[1] & lower_prev_reg);
  assign upper_pin_evt = edge_hit(edge_gate_reg[7:6], upper_sync_reg[1] & ~upper_prev_reg,
                                  ~upper_sync_reg[1] & upper_prev_reg);

  // gate source: the pin, or the pwm output when pwm gating is on
  assign gate_level = pwm_gate_en ? internal_gate_pwm_out : gate_sync_reg[1];
  assign gate_event = edge_hit(edge_gate_reg[3:2], gate_level & ~gate_prev_reg,
                               ~gate_level & gate_prev_reg);

  // free divider for the prescaled clocks; stops in standby to save power
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 6'h00;
    end else if (clk_en && running) begin
      div_reg <= div_reg + 6'h01;
    end
  end

  // lower counter clock and wrap
  assign lower_tick = running && gate_level && ctrl_status_reg[`AEC_BIT_CUEL]
    && ctrl_status_reg[`AEC_BIT_CRCL]
    && src_tick(clock_select_reg[5:4], lower_pin_evt, div_reg);
  assign lower_wrap = lower_tick && (lower_counter_reg == 8'hFF);

  // upper clock: lower overflow when cascaded, own select when split
  assign upper_src = split ? src_tick(clock_select_reg[7:6], upper_pin_evt, div_reg)
                           : lower_wrap;
  assign upper_tick = running && gate_level && ctrl_status_reg[`AEC_BIT_UPPER_COUNT_ENABLE]
    && ctrl_status_reg[`AEC_BIT_UPPER_RESET_CONTROL] && upper_src;
  assign upper_wrap = upper_tick && (upper_counter_reg == 8'hFF);

  // lower counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lower_counter_reg <= `AEC_RST_ZERO;
    end else if (clk_en) begin
      if (!ctrl_status_reg[`AEC_BIT_CRCL]) begin
        lower_counter_reg <= `AEC_RST_ZERO;
      end else if (lower_tick) begin
        lower_counter_reg <= lower_counter_reg + 8'h01;
      end
    end
  end

  // upper counter; in cascade it carries the high byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      upper_counter_reg <= `AEC_RST_ZERO;
    end else if (clk_en) begin
      if (!ctrl_status_reg[`AEC_BIT_UPPER_RESET_CONTROL]) begin
        upper_counter_reg <= `AEC_RST_ZERO;
      end else if (upper_tick) begin
        upper_counter_reg <= upper_counter_reg + 8'h01;
      end
    end
  end

  // control/status: set of an overflow flag wins over a clearing write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_status_reg <= `AEC_RST_ZERO;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_status_reg[5:0] <= reg_wdata[5:0];
      end
      if (upper_wrap) begin
        ctrl_status_reg[`AEC_BIT_OVH] <= 1'b1;
      end else if (wr_ctrl && ovh_armed_reg && !reg_wdata[`AEC_BIT_OVH]) begin
        ctrl_status_reg[`AEC_BIT_OVH] <= 1'b0;
      end
      if (lower_wrap && split) begin
        ctrl_status_reg[`AEC_BIT_OVL] <= 1'b1;
      end else if (wr_ctrl && ovl_armed_reg && !reg_wdata[`AEC_BIT_OVL]) begin
        ctrl_status_reg[`AEC_BIT_OVL] <= 1'b0;
      end
    end
  end

  // a flag read as one arms its clear; any write to the register disarms
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovh_armed_reg <= 1'b0;
      ovl_armed_reg <= 1'b0;
    end else if (clk_en) begin
      if (rd_ctrl) begin
        ovh_armed_reg <= ctrl_status_reg[`AEC_BIT_OVH];
        ovl_armed_reg <= ctrl_status_reg[`AEC_BIT_OVL];
      end else if (wr_ctrl) begin
        ovh_armed_reg <= 1'b0;
        ovl_armed_reg <= 1'b0;
      end
    end
  end

  // plain configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clock_stop_reg <= `AEC_RST_CLOCK_STOP;
      clock_select_reg <= `AEC_RST_ZERO;
      edge_gate_reg <= `AEC_RST_ZERO;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `AEC_OFS_CLOCK_STOP) begin
        clock_stop_reg <= reg_wdata;
      end
      if (reg_addr == `AEC_OFS_CLOCK_SELECT) begin
        clock_select_reg <= reg_wdata;
      end
      if (reg_addr == `AEC_OFS_EDGE_GATE) begin
        edge_gate_reg <= reg_wdata;
      end
    end
  end

  // pwm compare and data; software must keep data below compare
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_compare_reg <= 16'h0000;
      pwm_data_reg <= 16'h0000;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `AEC_OFS_PWM_CMP_HI) begin
        pwm_compare_reg[15:8] <= reg_wdata;
      end
      if (reg_addr == `AEC_OFS_PWM_CMP_LO) begin
        pwm_compare_reg[7:0] <= reg_wdata;
      end
      if (reg_addr == `AEC_OFS_PWM_DAT_HI) begin
        pwm_data_reg[15:8] <= reg_wdata;
      end
      if (reg_addr == `AEC_OFS_PWM_DAT_LO) begin
        pwm_data_reg[7:0] <= reg_wdata;
      end
    end
  end

  // pwm source clock: /2 .. /64; codes 6 and 7 repeat /32 and /64
  assign pwm_div_n = clock_select_reg[3] ? {2'h2, clock_select_reg[1]} + 3'h1
                                         : clock_select_reg[3:1] + 3'h1;
  assign pwm_src_tick = div_tick(div_reg, pwm_div_n);

  // pwm period counter: runs 0..compare while pwm gating is enabled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_count_reg <= 16'h0000;
    end else if (clk_en) begin
      if (!pwm_gate_en) begin
        pwm_count_reg <= 16'h0000;
      end else if (pwm_src_tick && running) begin
        if (pwm_count_reg >= pwm_compare_reg) begin
          pwm_count_reg <= 16'h0000;
        end else begin
          pwm_count_reg <= pwm_count_reg + 16'h0001;
        end
      end
    end
  end

  // pwm output registered: low for data+1 periods, then high till wrap
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      internal_gate_pwm_out <= 1'b0;
    end else if (clk_en) begin
      internal_gate_pwm_out <= pwm_gate_en && (pwm_count_reg > pwm_data_reg);
    end
  end

  // gate interrupt request, set wins over a clearing write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gate_request_flag_reg <= 1'b0;
      gate_irq_enable_reg <= 1'b0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == `AEC_OFS_IRQ_EN_ONE) begin
        gate_irq_enable_reg <= reg_wdata[`AEC_BIT_REQ];
      end
      if (gate_event && running) begin
        gate_request_flag_reg <= 1'b1;
      end else if (reg_wr && reg_addr == `AEC_OFS_IRQ_REQ_ONE && !reg_wdata[`AEC_BIT_REQ]) begin
        gate_request_flag_reg <= 1'b0;
      end
    end
  end

  // counter interrupt request on any overflow
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      counter_request_flag_reg <= 1'b0;
      counter_irq_enable_reg <= 1'b0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == `AEC_OFS_IRQ_EN_TWO) begin
        counter_irq_enable_reg <= reg_wdata[`AEC_BIT_REQ];
      end
      if (upper_wrap || (lower_wrap && split)) begin
        counter_request_flag_reg <= 1'b1;
      end else if (reg_wr && reg_addr == `AEC_OFS_IRQ_REQ_TWO && !reg_wdata[`AEC_BIT_REQ]) begin
        counter_request_flag_reg <= 1'b0;
      end
    end
  end

  // interrupt lines to the processor, registered
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      counter_irq <= 1'b0;
      gate_irq <= 1'b0;
    end else if (clk_en) begin
      counter_irq <= counter_request_flag_reg && counter_irq_enable_reg;
      gate_irq <= gate_request_flag_reg && gate_irq_enable_reg;
    end
  end

  // read data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          `AEC_OFS_UPPER_COUNT: reg_rdata <= upper_counter_reg;
          `AEC_OFS_LOWER_COUNT: reg_rdata <= lower_counter_reg;
          `AEC_OFS_CLOCK_STOP: reg_rdata <= clock_stop_reg;
          `AEC_OFS_CTRL_STATUS: reg_rdata <= ctrl_status_reg;
          `AEC_OFS_CLOCK_SELECT: reg_rdata <= clock_select_reg;
          `AEC_OFS_EDGE_GATE: reg_rdata <= edge_gate_reg;
          `AEC_OFS_PWM_CMP_HI: reg_rdata <= pwm_compare_reg[15:8];
          `AEC_OFS_PWM_CMP_LO: reg_rdata <= pwm_compare_reg[7:0];
          `AEC_OFS_PWM_DAT_HI: reg_rdata <= pwm_data_reg[15:8];
          `AEC_OFS_PWM_DAT_LO: reg_rdata <= pwm_data_reg[7:0];
          `AEC_OFS_IRQ_REQ_ONE: reg_rdata <= {7'h00, gate_request_flag_reg};
          `AEC_OFS_IRQ_EN_ONE: reg_rdata <= {7'h00, gate_irq_enable_reg};
          `AEC_OFS_IRQ_REQ_TWO: reg_rdata <= {7'h00, counter_request_flag_reg};
          `AEC_OFS_IRQ_EN_TWO: reg_rdata <= {7'h00, counter_irq_enable_reg};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // aec_top

/* File: bench/aec_top_asserts.sv */
// concurrent checks on the event counter register port and request outputs
`timescale 1ns/10ps
`include "aec_defines.svh"
module aec_top_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire aec_pkg::aec_addr_t reg_addr,
  input wire aec_pkg::aec_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire aec_pkg::aec_byte_t reg_rdata,
  input wire logic internal_gate_pwm_out,
  input wire logic counter_irq,
  input wire logic gate_irq
);
  import aec_pkg::*;
  aec_byte_t stop_q;
  logic [4:0] ctrl_q;
  logic pwm_en_q;
  logic gate_en_q;
  logic cnt_en_q;
  // shadows of written control bits, so read-back is judged without the bodies
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stop_q <= `AEC_RST_CLOCK_STOP;
      ctrl_q <= 5'h00;
      pwm_en_q <= 1'b0;
      gate_en_q <= 1'b0;
      cnt_en_q <= 1'b0;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        `AEC_OFS_CLOCK_STOP: stop_q <= reg_wdata;
        `AEC_OFS_CTRL_STATUS: ctrl_q <= reg_wdata[4:0];
        `AEC_OFS_EDGE_GATE: pwm_en_q <= reg_wdata[0];
        `AEC_OFS_IRQ_EN_ONE: gate_en_q <= reg_wdata[0];
        `AEC_OFS_IRQ_EN_TWO: cnt_en_q <= reg_wdata[0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_rdata_idle;
    $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_reset_exit;
    $rose(rst_n) |-> !counter_irq && !gate_irq && reg_rdata == 8'h00;
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("outputs busy after reset");
  property p_stop_rb;
    $past(reg_rd && reg_addr == `AEC_OFS_CLOCK_STOP) |-> reg_rdata == $past(stop_q);
  endproperty
  a_stop_rb: assert property (p_stop_rb) else $error("clock stop read-back wrong");
  property p_ctrl_rb;
    $past(reg_rd && reg_addr == `AEC_OFS_CTRL_STATUS) |-> reg_rdata[4:0] == $past(ctrl_q);
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control read-back wrong");
  // the lower counter held by its reset-control bit must read zero
  property p_lower_held;
    reg_rd && reg_addr == `AEC_OFS_LOWER_COUNT && !ctrl_q[0] && $past(!ctrl_q[0])
      |=> reg_rdata == 8'h00;
  endproperty
  a_lower_held: assert property (p_lower_held) else $error("held lower count not zero");
  property p_pwm_off;
    !pwm_en_q && $past(!pwm_en_q) && $past(!pwm_en_q, 2) |-> !internal_gate_pwm_out;
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm output while disabled");
  property p_cnt_irq;
    counter_irq |-> cnt_en_q || $past(cnt_en_q);
  endproperty
  a_cnt_irq: assert property (p_cnt_irq) else $error("counter irq without enable");
  property p_gate_irq;
    gate_irq |-> gate_en_q || $past(gate_en_q);
  endproperty
  a_gate_irq: assert property (p_gate_irq) else $error("gate irq without enable");
  c_cnt_irq: cover property (counter_irq);
  c_gate_irq: cover property (gate_irq);
  c_pwm: cover property ($fell(internal_gate_pwm_out));
endmodule // aec_top_asserts
bind aec_top aec_top_asserts i_aec_top_asserts (.clk_sys, .rst_n, .clk_en, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .internal_gate_pwm_out, .counter_irq, .gate_irq);

/* File: bench/aec_event_src.sv */
// far-side model: event sources on both counter pins and the external gate level
`timescale 1ns/10ps
module aec_event_src (
  input wire logic clk_sys,
  output logic upper_event_pin,
  output logic lower_event_pin,
  output logic gate_pin
);
  // pins idle high; gate starts open so counting is possible
  initial begin
    upper_event_pin = 1'b1;
    lower_event_pin = 1'b1;
    gate_pin = 1'b1;
  end
  // each level lasts three clocks, longer than the two-flop synchroniser needs
  task automatic pulse(input logic upper, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (upper) upper_event_pin <= 1'b0;
      else lower_event_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
      if (upper) upper_event_pin <= 1'b1;
      else lower_event_pin <= 1'b1;
      repeat (2) @(posedge clk_sys);
    end
    repeat (5) @(posedge clk_sys); // last edge must reach the counter
  endtask
  task automatic set_gate(input logic lvl);
    @(posedge clk_sys);
    gate_pin <= lvl;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule // aec_event_src

/* File: bench/tb_top.sv */
// self-checking bench for the event counter
`timescale 1ns/10ps
`include "aec_defines.svh"
module tb_top;
  import aec_pkg::*;
  logic clk_sys, rst_n, clk_en, reg_wr, reg_rd;
  aec_addr_t reg_addr;
  aec_byte_t reg_wdata, reg_rdata, rd_val;
  logic upper_event_pin, lower_event_pin, gate_pin, internal_gate_pwm_out, counter_irq, gate_irq;
  int errors, comparisons, lows;
  aec_top i_aec_top (.clk_sys, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .upper_event_pin, .lower_event_pin, .gate_pin, .internal_gate_pwm_out,
    .counter_irq, .gate_irq);
  aec_event_src i_aec_event_src (.clk_sys, .upper_event_pin, .lower_event_pin, .gate_pin);
  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic wr(input aec_addr_t a, input aec_byte_t d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe, so sample mid-cycle there
  task automatic rd(input aec_addr_t a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    rd_val = reg_rdata;
  endtask
  task automatic chk(input string what, input aec_byte_t exp, input aec_byte_t got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input aec_addr_t a, input aec_byte_t exp, input string what);
    rd(a);
    chk(what, exp, rd_val);
  endtask
  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog: the sequence needs a few thousand cycles
  initial begin
    #(40 * 20000);
    errors++;
    end_sim();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    errors = 0;
    comparisons = 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk(`AEC_OFS_CLOCK_STOP, 8'hFF, "clock_stop");
    rchk(`AEC_OFS_CTRL_STATUS, 8'h00, "ctrl_status");
    rchk(`AEC_OFS_CLOCK_SELECT, 8'h00, "clock_select");
    rchk(`AEC_OFS_UPPER_COUNT, 8'h00, "upper_count");
    rchk(4'hE, 8'h00, "unmapped");
    i_aec_event_src.pulse(1'b0, 2);
    rchk(`AEC_OFS_LOWER_COUNT, 8'h00, "lower_held");
    wr(`AEC_OFS_CTRL_STATUS, 8'h0F);
    wr(`AEC_OFS_UPPER_COUNT, 8'h55);
    i_aec_event_src.pulse(1'b0, 3);
    rchk(`AEC_OFS_LOWER_COUNT, 8'h03, "lower_fall");
    rchk(`AEC_OFS_UPPER_COUNT, 8'h00, "upper_ro");
    wr(`AEC_OFS_EDGE_GATE, 8'h10);
    i_aec_event_src.pulse(1'b0, 2);
    rchk(`AEC_OFS_LOWER_COUNT, 8'h05, "lower_rise");
    wr(`AEC_OFS_EDGE_GATE, 8'h20);
    i_aec_event_src.pulse(1'b0, 2);
    rchk(`AEC_OFS_LOWER_COUNT, 8'h09, "lower_both");
    i_aec_event_src.set_gate(1'b0);
    i_aec_event_src.pulse(1'b0, 3);
    rchk(`AEC_OFS_LOWER_COUNT, 8'h09, "gate_low");
    i_aec_event_src.set_gate(1'b1);
    wr(`AEC_OFS_CTRL_STATUS, 8'h0B);
    i_aec_event_src.pulse(1'b0, 2);
    rchk(`AEC_OFS_LOWER_COUNT, 8'h09, "count_off");
    wr(`AEC_OFS_CTRL_STATUS, 8'h0F);
    wr(`AEC_OFS_CLOCK_STOP, 8'hF7);
    i_aec_event_src.pulse(1'b0, 2);
    rchk(`AEC_OFS_LOWER_COUNT, 8'h09, "standby");
    wr(`AEC_OFS_CLOCK_STOP, 8'hFF);
    // cascade: about 300 lower ticks carry exactly once into the upper byte
    wr(`AEC_OFS_CLOCK_SELECT, 8'h10);
    repeat (600) @(posedge clk_sys);
    wr(`AEC_OFS_CTRL_STATUS, 8'h0B);
    rchk(`AEC_OFS_UPPER_COUNT, 8'h01, "cascade");
    rchk(`AEC_OFS_CTRL_STATUS, 8'h0B, "no_ovl_16");
    // split mode, both bytes at clock/2 overflow once
    wr(`AEC_OFS_CTRL_STATUS, 8'h10);
    wr(`AEC_OFS_CLOCK_SELECT, 8'h50);
    wr(`AEC_OFS_IRQ_EN_TWO, 8'h01);
    wr(`AEC_OFS_CTRL_STATUS, 8'h1F);
    repeat (600) @(posedge clk_sys);
    wr(`AEC_OFS_CTRL_STATUS, 8'h13);
    rchk(`AEC_OFS_CTRL_STATUS, 8'hD3, "ovf_flags");
    chk("counter_irq", 8'h01, {7'h00, counter_irq});
    rchk(`AEC_OFS_IRQ_REQ_TWO, 8'h01, "counter_req");
    wr(`AEC_OFS_CTRL_STATUS, 8'h13);
    rchk(`AEC_OFS_CTRL_STATUS, 8'h13, "ovf_clear");
    wr(`AEC_OFS_CTRL_STATUS, 8'hD3);
    rchk(`AEC_OFS_CTRL_STATUS, 8'h13, "ovf_no_set");
    wr(`AEC_OFS_IRQ_REQ_TWO, 8'h00);
    rchk(`AEC_OFS_IRQ_REQ_TWO, 8'h00, "counter_req_clr");
    chk("counter_irq_clr", 8'h00, {7'h00, counter_irq});
    // upper pin, rising edges, in split mode
    wr(`AEC_OFS_CLOCK_SELECT, 8'h00);
    wr(`AEC_OFS_EDGE_GATE, 8'h40);
    wr(`AEC_OFS_CTRL_STATUS, 8'h10);
    wr(`AEC_OFS_CTRL_STATUS, 8'h1F);
    i_aec_event_src.pulse(1'b1, 2);
    rchk(`AEC_OFS_UPPER_COUNT, 8'h02, "upper_pin");
    rchk(`AEC_OFS_LOWER_COUNT, 8'h00, "lower_quiet");
    // split mode, upper at clock/4 and lower at clock/8 over 162 enabled cycles
    wr(`AEC_OFS_CTRL_STATUS, 8'h10);
    wr(`AEC_OFS_CLOCK_SELECT, 8'hB0);
    wr(`AEC_OFS_CTRL_STATUS, 8'h1F);
    repeat (160) @(posedge clk_sys);
    wr(`AEC_OFS_CTRL_STATUS, 8'h13);
    rd(`AEC_OFS_UPPER_COUNT);
    chk("upper_div4", 8'h01, {7'h00, rd_val >= 8'h28 && rd_val <= 8'h29});
    rd(`AEC_OFS_LOWER_COUNT);
    chk("lower_div8", 8'h01, {7'h00, rd_val >= 8'h14 && rd_val <= 8'h15});
    // gate interrupt edge codes: falling, rising, both
    wr(`AEC_OFS_IRQ_EN_ONE, 8'h01);
    for (int code = 0; code < 3; code++) begin
      wr(`AEC_OFS_EDGE_GATE, 8'(code << 2));
      wr(`AEC_OFS_IRQ_REQ_ONE, 8'h00);
      i_aec_event_src.set_gate(1'b0);
      rchk(`AEC_OFS_IRQ_REQ_ONE, {7'h00, code != 1}, "gate_fall");
      chk("gate_irq", {7'h00, code != 1}, {7'h00, gate_irq});
      wr(`AEC_OFS_IRQ_REQ_ONE, 8'h00);
      i_aec_event_src.set_gate(1'b1);
      rchk(`AEC_OFS_IRQ_REQ_ONE, {7'h00, code != 0}, "gate_rise");
    end
    // pwm: compare 3, data 1, pwm clock/4; data kept below compare
    i_aec_event_src.set_gate(1'b0);
    wr(`AEC_OFS_PWM_CMP_HI, 8'h00);
    wr(`AEC_OFS_PWM_CMP_LO, 8'h03);
    wr(`AEC_OFS_PWM_DAT_HI, 8'h00);
    wr(`AEC_OFS_PWM_DAT_LO, 8'h01);
    wr(`AEC_OFS_CLOCK_SELECT, 8'h52);
    wr(`AEC_OFS_CTRL_STATUS, 8'h10);
    wr(`AEC_OFS_IRQ_REQ_ONE, 8'h00);
    wr(`AEC_OFS_EDGE_GATE, 8'h05);
    wr(`AEC_OFS_CTRL_STATUS, 8'h1F);
    lows = 0;
    // 64 cycles hold four 16-cycle periods, so the low count needs no phase
    repeat (64) begin
      @(negedge clk_sys);
      if (internal_gate_pwm_out === 1'b0) lows++;
    end
    wr(`AEC_OFS_CTRL_STATUS, 8'h13);
    chk("pwm_low", 8'h20, lows[7:0]);
    rd(`AEC_OFS_LOWER_COUNT);
    chk("pwm_gated", 8'h01, {7'h00, rd_val >= 8'h0C && rd_val <= 8'h16});
    rchk(`AEC_OFS_IRQ_REQ_ONE, 8'h01, "pwm_req");
    chk("pwm_irq", 8'h01, {7'h00, gate_irq});
    wr(`AEC_OFS_EDGE_GATE, 8'h00);
    repeat (4) @(negedge clk_sys);
    chk("pwm_off", 8'h00, {7'h00, internal_gate_pwm_out});
    end_sim();
  end
endmodule // tb_top
